/* File: logic/bsc_pkg.sv */
// Constants, register map and carrier types for the boundary-scan and test-port control block.
package bsc_pkg;
	// Chain geometry.
	localparam int CHAIN_LEN = 57;
	localparam int PINS = 32;
	localparam int PIN_PER_PORT = 8;
	localparam int CELLS_PER_PIN = 2;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;
	localparam int PA_DATA_BASE = 0;
	localparam int PB_DATA_TOP = 56;
	localparam int PD_DATA_TOP = 39;
	localparam int PD_DATA_PINS = 7;
	localparam int PD_CTRL_PINS = 6;
	localparam int PD_LAST_DATA = 27;
	localparam int PC_DATA_TOP = 23;
	localparam int PC_CTRL_LOW = 15;
	localparam int RST_OBS_BIT = 40;
	localparam logic [5:0] PC_DATA_IDX [0:7] = '{6'h17, 6'h15, 6'h13, 6'h00, 6'h00, 6'h00, 6'h12, 6'h10};
	localparam logic [5:0] PC_CTRL_IDX [0:7] = '{6'h16, 6'h14, 6'h00, 6'h00, 6'h00, 6'h00, 6'h11, 6'h0f};
	localparam logic [7:0] PC_DATA_OK = 8'hc7;
	localparam logic [7:0] PC_CTRL_OK = 8'hc3;
	// Instruction register.
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
	localparam logic [IR_W-1:0] IR_CORE_RST = 4'hc;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// Register map.
	localparam logic [7:0] ADDR_STATUS = 8'h34;
	localparam logic [7:0] ADDR_CTRL = 8'h35;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h36;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h37;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_RW_MASK = 8'h13;
	localparam int CTRL_DISABLE = 7;
	localparam int CTRL_PULLUP = 4;
	localparam int CTRL_VSEL = 1;
	localparam int CTRL_VCE = 0;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] STAT_MASK = 8'h1f;
	localparam int ST_TPRST = 4;
	localparam int ST_WDT = 3;
	localparam int ST_BOR = 2;
	localparam int ST_EXT = 1;
	localparam int ST_POR = 0;
	localparam logic [7:0] IRQ_MASK_W = 8'h07;
	localparam int IRQ_TPRST = 0;
	localparam int IRQ_DIS_CHG = 1;
	localparam int IRQ_DW_FAIL = 2;
	// Timed double-write window in clock cycles.
	localparam logic [2:0] DW_WINDOW_CYC = 3'h4;

	typedef struct packed {
		logic [7:0] pd;
		logic [7:0] pc;
		logic [7:0] pb;
		logic [7:0] pa;
	} bsc_pins_t;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
		TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} bsc_tap_t;
endpackage : bsc_pkg

/* File: logic/bsc_scan_ctrl.sv */
// Boundary-scan chain, test access port and test-port control/status registers.
// How it works
// - Port D cells run from bit 39 down, data then control per pin from pin 0, ending with pin 6 data at bit 27.
// - Bits 23..15 hold port C pins 0,1,2,6,7 and bits 14..0 hold port A pin 7 down to pin 0, data first.
// - The test port works only while the disable bit is clear and the test-enable fuse is programmed.
// - The disable bit changes only when the same value is written to it twice within four cycles.
// - The control register resets to zero; bits 7,4,1,0 are writable and bits 6,5,3,2 read as zero.
// - The status register holds five writable reset-cause flags at bits 4..0 and bits 7..5 read zero.
// - A reset caused by a one in the test reset register sets the test-port reset flag.
// - The test-port reset flag clears on power-on reset or a software write of zero, nothing else.
// - Bit 0 of the chain is shifted in first and shifted out first.
// - Each data cell captures the pin's input level and drives its output data, each control cell captures and drives its output enable.
// - Bit 40 observes the active-low reset pin and bits 56..41 carry port B pins 0..7.
//
// Design decision made here: the plain strobed port.
module bsc_scan_ctrl (
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Register port.
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Test access port pins, sampled by SYS_CLK.
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	output logic TDO,
	output logic TDO_OE,
	// Port pins.
	input wire bsc_pkg::bsc_pins_t PIN_IN,
	input wire bsc_pkg::bsc_pins_t CORE_DO,
	input wire bsc_pkg::bsc_pins_t CORE_OE,
	output bsc_pkg::bsc_pins_t PIN_DO,
	output bsc_pkg::bsc_pins_t PIN_OE,
	// Reset pin, fuse and reset-cause events from the reset controller.
	input wire logic RESET_N_PIN,
	input wire logic TEST_ENABLE_FUSE,
	input wire logic POR_EVT,
	input wire logic WDT_EVT,
	input wire logic BOR_EVT,
	input wire logic EXT_EVT,
	// Core-side outputs.
	output logic CORE_RESET_REQ,
	output logic TEST_PORT_ACTIVE,
	output logic PULLUP_DISABLE,
	output logic VECTOR_SELECT,
	output logic VECTOR_CHANGE_EN,
	output logic IRQ
);
	import bsc_pkg::*;

	localparam int SY_TCK = PINS;
	localparam int SY_TMS = PINS + 1;
	localparam int SY_TDI = PINS + 2;
	localparam int SY_RSTN = PINS + 3;
	localparam int SY_FUSE = PINS + 4;
	localparam int SYNC_W = PINS + 5;

	// Returns {valid, chain index} of the data or control cell of one pin.
	function automatic logic [6:0] cell_of(input int port, input int pin, input logic ctrl);
		logic [6:0] r;
		r = '0;
		case (port)
			PORT_A: if (!ctrl || pin != 0) begin
				r = {1'b1, 6'(PA_DATA_BASE + CELLS_PER_PIN * pin - int'(ctrl))};
			end
			PORT_B: r = {1'b1, 6'(PB_DATA_TOP - CELLS_PER_PIN * pin - int'(ctrl))};
			PORT_C: if (ctrl ? PC_CTRL_OK[pin] : PC_DATA_OK[pin]) begin
				r = {1'b1, ctrl ? PC_CTRL_IDX[pin] : PC_DATA_IDX[pin]};
			end
			PORT_D: if (ctrl ? pin < PD_CTRL_PINS : pin < PD_DATA_PINS) begin
				r = {1'b1, 6'(PD_DATA_TOP - CELLS_PER_PIN * pin - int'(ctrl))};
			end
			default: r = '0;
		endcase
		return r;
	endfunction : cell_of

	function automatic bsc_tap_t tap_next(input bsc_tap_t s, input logic tms);
		bsc_tap_t n;
		n = s;
		case (s)
			TAP_RESET: n = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: n = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: n = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: n = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: n = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: n = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: n = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
			default: n = TAP_RESET;
		endcase
		return n;
	endfunction : tap_next

	// Synchronisers. Only the second stage and the edge detector behind it are read.
	logic [SYNC_W-1:0] sync1_q, sync2_q;
	logic tck_prev_q;
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
			tck_prev_q <= 1'b0;
		end else begin
			sync1_q <= {TEST_ENABLE_FUSE, RESET_N_PIN, TDI, TMS, TCK, PIN_IN};
			sync2_q <= sync1_q;
			tck_prev_q <= sync2_q[SY_TCK];
		end
	end

	logic [PINS-1:0] pin_s;
	logic tck_rise, tck_fall, tms_s, tdi_s, rst_n_s, fuse_s;
	assign pin_s = sync2_q[PINS-1:0];
	assign tck_rise = sync2_q[SY_TCK] && !tck_prev_q;
	assign tck_fall = !sync2_q[SY_TCK] && tck_prev_q;
	assign tms_s = sync2_q[SY_TMS];
	assign tdi_s = sync2_q[SY_TDI];
	assign rst_n_s = sync2_q[SY_RSTN];
	assign fuse_s = sync2_q[SY_FUSE];

	// Register state.
	logic [7:0] ctrl_q, ctrl_d, stat_q, stat_d, irq_q, irq_d, mask_q, mask_d, rdata_q, rdata_d;
	logic [2:0] win_q, win_d;
	logic pend_q, pend_d, irq_out_q, irq_out_d;
	logic tap_en;
	assign tap_en = fuse_s && !ctrl_q[CTRL_DISABLE];

	// Test access port state.
	bsc_tap_t tap_q, tap_d;
	logic [IR_W-1:0] ir_q, ir_d, irsh_q, irsh_d;
	logic [CHAIN_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d, cap_vec;
	logic byp_q, byp_d, rsh_q, rsh_d, rst_q, rst_d, tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
	logic tp_act_q, tp_act_d;
	logic [PINS-1:0] pin_do_q, pin_do_d, pin_oe_q, pin_oe_d;
	logic extest, scan_sel;
	logic [6:0] dc, cc;
	assign extest = tap_en && ir_q == IR_EXTEST;
	assign scan_sel = ir_q == IR_EXTEST || ir_q == IR_SAMPLE;
	// The activity flag is registered from the next state so it tracks the controller exactly.
	assign tp_act_d = tap_d != TAP_RESET;

	// Capture vector and pin multiplexing through the cell map.
	always_comb begin
		cap_vec = '0;
		pin_do_d = CORE_DO;
		pin_oe_d = CORE_OE;
		dc = '0;
		cc = '0;
		for (int i = 0; i < PINS; i++) begin
			dc = cell_of(i / PIN_PER_PORT, i % PIN_PER_PORT, 1'b0);
			cc = cell_of(i / PIN_PER_PORT, i % PIN_PER_PORT, 1'b1);
			if (dc[6]) begin
				cap_vec[dc[5:0]] = pin_s[i];
				if (extest) begin
					pin_do_d[i] = upd_q[dc[5:0]];
				end
			end
			if (cc[6]) begin
				cap_vec[cc[5:0]] = pin_oe_q[i];
				if (extest) begin
					pin_oe_d[i] = upd_q[cc[5:0]];
				end
			end
		end
		cap_vec[RST_OBS_BIT] = rst_n_s;
	end

	always_comb begin
		tap_d = tap_q;
		ir_d = ir_q;
		irsh_d = irsh_q;
		bsr_d = bsr_q;
		upd_d = upd_q;
		byp_d = byp_q;
		rsh_d = rsh_q;
		rst_d = rst_q;
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		if (!tap_en) begin
			// A disabled port sits in reset so that re-enabling starts from a known state.
			tap_d = TAP_RESET;
			ir_d = IR_BYPASS;
			rst_d = 1'b0;
			tdo_oe_d = 1'b0;
		end else if (tck_rise) begin
			case (tap_q)
				TAP_RESET: begin
					ir_d = IR_BYPASS;
					rst_d = 1'b0;
				end
				TAP_CAP_DR: begin
					if (scan_sel) begin
						bsr_d = cap_vec;
					end
					rsh_d = rst_q;
					byp_d = 1'b0;
				end
				TAP_SHIFT_DR: begin
					if (scan_sel) begin
						bsr_d = {tdi_s, bsr_q[CHAIN_LEN-1:1]};
					end else if (ir_q == IR_CORE_RST) begin
						rsh_d = tdi_s;
					end else begin
						byp_d = tdi_s;
					end
				end
				TAP_UPD_DR: begin
					if (scan_sel) begin
						upd_d = bsr_q;
					end else if (ir_q == IR_CORE_RST) begin
						rst_d = rsh_q;
					end
				end
				TAP_CAP_IR: irsh_d = IR_CAPTURE;
				TAP_SHIFT_IR: irsh_d = {tdi_s, irsh_q[IR_W-1:1]};
				TAP_UPD_IR: ir_d = irsh_q;
				default: ;
			endcase
			tap_d = tap_next(tap_q, tms_s);
		end else if (tck_fall) begin
			// TDO changes on the falling edge so the tester samples a settled bit.
			tdo_oe_d = tap_q == TAP_SHIFT_DR || tap_q == TAP_SHIFT_IR;
			if (tap_q == TAP_SHIFT_IR) begin
				tdo_d = irsh_q[0];
			end else if (tap_q == TAP_SHIFT_DR) begin
				tdo_d = scan_sel ? bsr_q[0] : (ir_q == IR_CORE_RST ? rsh_q : byp_q);
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			tap_q <= TAP_RESET;
			ir_q <= IR_BYPASS;
			irsh_q <= '0;
			bsr_q <= '0;
			upd_q <= '0;
			byp_q <= 1'b0;
			rsh_q <= 1'b0;
			rst_q <= 1'b0;
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
			tp_act_q <= 1'b0;
			pin_do_q <= '0;
			pin_oe_q <= '0;
		end else begin
			tap_q <= tap_d;
			ir_q <= ir_d;
			irsh_q <= irsh_d;
			bsr_q <= bsr_d;
			upd_q <= upd_d;
			byp_q <= byp_d;
			rsh_q <= rsh_d;
			rst_q <= rst_d;
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
			tp_act_q <= tp_act_d;
			pin_do_q <= pin_do_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// Registers, timed double write and interrupt status.
	logic wr_ctrl, wr_stat, tprst_set, dw_ok;
	logic [7:0] ev;
	assign wr_ctrl = REG_WR && REG_ADDR == ADDR_CTRL;
	assign wr_stat = REG_WR && REG_ADDR == ADDR_STATUS;
	assign tprst_set = rst_d && !rst_q;
	assign dw_ok = wr_ctrl && win_q != '0 && REG_WDATA[CTRL_DISABLE] == pend_q;

	always_comb begin
		ctrl_d = ctrl_q;
		stat_d = stat_q;
		mask_d = mask_q;
		win_d = win_q;
		pend_d = pend_q;
		rdata_d = '0;
		ev = '0;
		if (win_q != '0) begin
			win_d = win_q - 3'h1;
		end
		if (wr_ctrl) begin
			ctrl_d = (REG_WDATA & CTRL_RW_MASK) | (ctrl_q & ~CTRL_RW_MASK);
			if (dw_ok) begin
				ctrl_d[CTRL_DISABLE] = pend_q;
				ev[IRQ_DIS_CHG] = pend_q != ctrl_q[CTRL_DISABLE];
				win_d = '0;
			end else begin
				// Any other write only arms the window; the stored bit stays put.
				pend_d = REG_WDATA[CTRL_DISABLE];
				win_d = DW_WINDOW_CYC;
				ev[IRQ_DW_FAIL] = win_q != '0;
			end
		end else if (win_q == 3'h1) begin
			ev[IRQ_DW_FAIL] = 1'b1;
		end
		if (wr_stat) begin
			stat_d = REG_WDATA & STAT_MASK;
		end
		if (POR_EVT) begin
			stat_d[ST_TPRST] = 1'b0;
			stat_d[ST_POR] = 1'b1;
		end
		// Hardware set wins over a software clear in the same cycle.
		stat_d[ST_WDT] = stat_d[ST_WDT] | WDT_EVT;
		stat_d[ST_BOR] = stat_d[ST_BOR] | BOR_EVT;
		stat_d[ST_EXT] = stat_d[ST_EXT] | EXT_EVT;
		if (tprst_set) begin
			stat_d[ST_TPRST] = 1'b1;
		end
		ev[IRQ_TPRST] = tprst_set;
		if (REG_WR && REG_ADDR == ADDR_IRQ_MASK) begin
			mask_d = REG_WDATA & IRQ_MASK_W;
		end
		irq_d = ((REG_RD && REG_ADDR == ADDR_IRQ_STAT) ? 8'h00 : irq_q) | ev;
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_STATUS: rdata_d = stat_q & STAT_MASK;
				ADDR_CTRL: rdata_d = ctrl_q;
				ADDR_IRQ_STAT: rdata_d = irq_q;
				ADDR_IRQ_MASK: rdata_d = mask_q;
				default: rdata_d = '0;
			endcase
		end
		irq_out_d = |(irq_d & mask_d);
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ctrl_q <= CTRL_RESET;
			stat_q <= STAT_RESET;
			mask_q <= '0;
			irq_q <= '0;
			win_q <= '0;
			pend_q <= 1'b0;
			rdata_q <= '0;
			irq_out_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			win_q <= win_d;
			pend_q <= pend_d;
			rdata_q <= rdata_d;
			irq_out_q <= irq_out_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign TDO = tdo_q;
	assign TDO_OE = tdo_oe_q;
	assign PIN_DO = pin_do_q;
	assign PIN_OE = pin_oe_q;
	assign CORE_RESET_REQ = rst_q;
	assign TEST_PORT_ACTIVE = tp_act_q;
	assign PULLUP_DISABLE = ctrl_q[CTRL_PULLUP];
	assign VECTOR_SELECT = ctrl_q[CTRL_VSEL];
	assign VECTOR_CHANGE_EN = ctrl_q[CTRL_VCE];
	assign IRQ = irq_out_q;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	logic cap_scan;
	assign cap_scan = tap_en && tck_rise && tap_q == TAP_CAP_DR && scan_sel;

	chk_pd_order: assert property (
		cap_scan |=> bsr_q[PD_DATA_TOP] == $past(pin_s[PORT_D * PIN_PER_PORT])
			&& bsr_q[PD_LAST_DATA] == $past(pin_s[PORT_D * PIN_PER_PORT + PD_CTRL_PINS]))
		else $error("port D cell order wrong");
	chk_pc_pa_order: assert property (
		cap_scan |=> bsr_q[PC_DATA_TOP] == $past(pin_s[PORT_C * PIN_PER_PORT])
			&& bsr_q[PA_DATA_BASE] == $past(pin_s[PORT_A * PIN_PER_PORT])
			&& bsr_q[PC_CTRL_LOW] == $past(pin_oe_q[PORT_C * PIN_PER_PORT + 7]))
		else $error("port C or A cell order wrong");
	chk_rst_obs_cell: assert property (
		cap_scan |=> bsr_q[RST_OBS_BIT] == $past(rst_n_s)
			&& bsr_q[PB_DATA_TOP] == $past(pin_s[PORT_B * PIN_PER_PORT]))
		else $error("reset observe or port B cell wrong");
	chk_port_gate: assert property (
		!tap_en |=> tap_q == TAP_RESET && !TDO_OE)
		else $error("test port active while disabled");
	chk_dw_commit: assert property (
		$changed(ctrl_q[CTRL_DISABLE]) |-> $past(dw_ok))
		else $error("disable bit changed without double write");
	chk_dw_lone: assert property (
		wr_ctrl && win_q == '0 |=> ctrl_q[CTRL_DISABLE] == $past(ctrl_q[CTRL_DISABLE])
			&& win_q == DW_WINDOW_CYC)
		else $error("lone write changed disable bit");
	chk_ctrl_ro: assert property (
		REG_RD && REG_ADDR == ADDR_CTRL |=> REG_RDATA[6:5] == 2'h0 && REG_RDATA[3:2] == 2'h0)
		else $error("control read-only bits not zero");
	chk_stat_hi: assert property (
		REG_RD && REG_ADDR == ADDR_STATUS |=> REG_RDATA[7:5] == 3'h0
			&& REG_RDATA[4:0] == $past(stat_q[4:0]))
		else $error("status read wrong");
	chk_tprst_set: assert property (
		tprst_set |=> stat_q[ST_TPRST] ##1 CORE_RESET_REQ)
		else $error("test-port reset flag not set");
	chk_tprst_keep: assert property (
		stat_q[ST_TPRST] && !POR_EVT && !wr_stat |=> stat_q[ST_TPRST])
		else $error("test-port reset flag lost");
	chk_shift_lsb: assert property (
		tap_en && tck_rise && tap_q == TAP_SHIFT_DR && scan_sel
			|=> bsr_q[CHAIN_LEN-1] == $past(tdi_s) && bsr_q[0] == $past(bsr_q[1]))
		else $error("chain shift direction wrong");
	chk_extest_drive: assert property (
		extest |=> PIN_DO.pa[0] == $past(upd_q[PA_DATA_BASE])
			&& PIN_OE.pa[1] == $past(upd_q[PA_DATA_BASE + 1]))
		else $error("extest pin drive wrong");

	cov_dw_change: cover property (dw_ok ##1 $changed(ctrl_q[CTRL_DISABLE]));
	cov_core_reset: cover property (tprst_set);
	cov_extest: cover property (extest && tap_q == TAP_UPD_DR && tck_rise);
	cov_irq: cover property ($rose(IRQ));
endmodule : bsc_scan_ctrl

/* File: tb/bsc_jtag_model.sv */
// Tester model that drives the test access port from outside the device.
module bsc_jtag_model (
	// Test access port.
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// The clock stays low between frames. Output is read just after the rise, where it is settled.
	task automatic clk1(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80;
		tck = 1'b1;
		#10;
		q = tdo;
		#70;
		tck = 1'b0;
	endtask : clk1
	// Idle cycles toggle the data line so a stale level is never mistaken for data.
	task automatic goto_idle();
		logic q;
		#3.3;
		repeat (5) clk1(1'b1, ~tdi, q);
		clk1(1'b0, ~tdi, q);
	endtask : goto_idle
	task automatic shift(input logic ir, input int n, input logic [56:0] din,
		output logic [56:0] dout);
		logic q;
		// Frames start a little off the system clock edges so no pin moves on a sampling edge.
		#3.3;
		dout = '0;
		clk1(1'b1, ~tdi, q);
		if (ir) clk1(1'b1, ~tdi, q);
		clk1(1'b0, ~tdi, q);
		clk1(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			clk1(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk1(1'b1, ~tdi, q);
		clk1(1'b0, ~tdi, q);
	endtask : shift
endmodule : bsc_jtag_model

/* File: tb/tb_top.sv */
// Self-checking bench for the scan chain, test access port and test-port registers.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bsc_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rst_n_pin = 1'b1;
	logic fuse = 1'b1, por = 1'b0, wdt = 1'b0, bor = 1'b0, ext = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic tck, tms, tdi, tdo, tdo_oe, core_rst_req, tp_active, pu_dis, vsel, vce, irq;
	bsc_pins_t pin_in = '0, core_do = '0, core_oe = '0, pin_do, pin_oe;
	logic [31:0] drv_do, drv_oe;
	logic [56:0] din, dout;
	integer seed = 73034;
	int errors = 0, num_checks = 0;
	always #10 sys_clk = ~sys_clk;
	bsc_scan_ctrl DUT (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TCK(tck), .TMS(tms),
		.TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .PIN_IN(pin_in), .CORE_DO(core_do),
		.CORE_OE(core_oe), .PIN_DO(pin_do), .PIN_OE(pin_oe), .RESET_N_PIN(rst_n_pin),
		.TEST_ENABLE_FUSE(fuse), .POR_EVT(por), .WDT_EVT(wdt), .BOR_EVT(bor), .EXT_EVT(ext),
		.CORE_RESET_REQ(core_rst_req), .TEST_PORT_ACTIVE(tp_active), .PULLUP_DISABLE(pu_dis),
		.VECTOR_SELECT(vsel), .VECTOR_CHANGE_EN(vce), .IRQ(irq)
	);
	// A released data-out line shows the inverse of its last level, so a late enable corrupts reads.
	bsc_jtag_model jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));
	// Chain position of one cell, or -1 where the pin has no such cell.
	function automatic int cell_idx(input int port, input int pin, input int ctl);
		case (port)
			PORT_A: return (pin == 0 && ctl == 1) ? -1 : 2 * pin - ctl;
			PORT_B: return 56 - 2 * pin - ctl;
			PORT_D: return (pin == 7 || (pin == 6 && ctl == 1)) ? -1 : 39 - 2 * pin - ctl;
			default: begin
				if (pin < 2) return 23 - 2 * pin - ctl;
				if (pin == 2) return ctl ? -1 : 19;
				if (pin >= 6) return 18 - 2 * (pin - 6) - ctl;
				return -1;
			end
		endcase
	endfunction : cell_idx
	function automatic logic [56:0] cap_exp(input logic [31:0] pins, input logic [31:0] oe,
		input logic rn);
		logic [56:0] v;
		int ix;
		v = '0;
		v[40] = rn;
		for (int b = 0; b < 64; b++) begin
			ix = cell_idx(b / 16, (b / 2) % 8, b % 2);
			if (ix >= 0) v[ix] = (b % 2) ? oe[b / 2] : pins[b / 2];
		end
		return v;
	endfunction : cap_exp
	task automatic drive_exp(input logic [56:0] c);
		int ix;
		for (int b = 0; b < 64; b++) begin
			ix = cell_idx(b / 16, (b / 2) % 8, b % 2);
			if (b % 2) drv_oe[b / 2] = ix >= 0 ? c[ix] : core_oe[b / 2];
			else drv_do[b / 2] = ix >= 0 ? c[ix] : core_do[b / 2];
		end
	endtask : drive_exp
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		check(64'(reg_rdata & m), 64'(e));
	endtask : rdc
	task automatic pulse(input int k);
		@(posedge sys_clk);
		{por, wdt, bor, ext} <= 4'h8 >> k;
		@(posedge sys_clk);
		{por, wdt, bor, ext} <= 4'h0;
	endtask : pulse
	task automatic tally_and_finish();
		if (errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#1000000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		pin_in <= $random(seed);
		core_do <= $random(seed);
		core_oe <= $random(seed);
		rdc(ADDR_CTRL, CTRL_RESET);
		rdc(ADDR_STATUS, STAT_RESET);
		wr(ADDR_STATUS, 8'hff);
		rdc(ADDR_STATUS, STAT_MASK);
		wr(ADDR_STATUS, 8'h10);
		for (int k = 1; k < 4; k++) pulse(k);
		rdc(ADDR_STATUS, 8'h1e);
		pulse(0);
		rdc(ADDR_STATUS, 8'h01, 8'h11);
		wr(ADDR_STATUS, 8'h00);
		rdc(ADDR_STATUS, 8'h00);
		wr(8'h40, 8'hff);
		rdc(8'h40, 8'h00);
		wr(ADDR_CTRL, 8'hff);
		rdc(ADDR_CTRL, CTRL_RW_MASK);
		check(64'({pu_dis, vsel, vce}), 64'h7);
		wr(ADDR_IRQ_MASK, 8'h07);
		rdc(ADDR_IRQ_STAT, 8'h04);
		jtag.goto_idle();
		check(64'(tp_active), 64'h1);
		jtag.shift(1'b1, IR_W, 57'(IR_SAMPLE), dout);
		check(64'(dout[3:0]), 64'h1);
		repeat (4) @(negedge sys_clk);
		check(64'({pin_do, pin_oe}), 64'({core_do, core_oe}));
		// First pass samples and preloads, second pass drives the pins from the chain.
		for (int r = 0; r < 2; r++) begin
			@(posedge sys_clk);
			rst_n_pin <= ~r[0];
			din = 57'({$random(seed), $random(seed)});
			jtag.shift(1'b0, CHAIN_LEN, din, dout);
			check(64'(dout), 64'(cap_exp(pin_in, r ? drv_oe : 32'(core_oe), rst_n_pin)));
			if (r == 0) jtag.shift(1'b1, IR_W, 57'(IR_EXTEST), dout);
			drive_exp(din);
			repeat (4) @(negedge sys_clk);
			check(64'({pin_do, pin_oe}), {drv_do, drv_oe});
		end
		jtag.shift(1'b1, IR_W, 57'(IR_CORE_RST), dout);
		jtag.shift(1'b0, 1, 57'h1, dout);
		repeat (4) @(negedge sys_clk);
		check(64'({core_rst_req, irq}), 64'h3);
		rdc(ADDR_STATUS, 8'h10);
		rdc(ADDR_IRQ_STAT, 8'h01);
		jtag.shift(1'b0, 1, 57'h0, dout);
		repeat (4) @(negedge sys_clk);
		check(64'({core_rst_req, irq}), 64'h0);
		rdc(ADDR_STATUS, 8'h10);
		// Bypass captures zero and then hands each input bit straight back.
		jtag.shift(1'b1, IR_W, 57'(IR_BYPASS), dout);
		jtag.shift(1'b0, 2, 57'h3, dout);
		check(64'(dout[1:0]), 64'h2);
		// The disable bit is written while a debug session is still running, which ends it.
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_CTRL, 8'h80);
		rdc(ADDR_CTRL, 8'h80);
		check(64'({tp_active, irq}), 64'h1);
		rdc(ADDR_IRQ_STAT, 8'h02);
		jtag.goto_idle();
		check(64'(tp_active), 64'h0);
		// A lone write, a pair five cycles apart, then a pair four cycles apart.
		for (int g = 0; g < 3; g++) begin
			wr(ADDR_CTRL, 8'h00);
			repeat (g == 2 ? 2 : 3) @(posedge sys_clk);
			if (g > 0) wr(ADDR_CTRL, 8'h00);
			repeat (8) @(posedge sys_clk);
			rdc(ADDR_CTRL, g == 2 ? 8'h00 : 8'h80);
		end
		jtag.goto_idle();
		check(64'(tp_active), 64'h1);
		@(posedge sys_clk);
		fuse <= 1'b0;
		repeat (6) @(negedge sys_clk);
		check(64'(tp_active), 64'h0);
		tally_and_finish();
	end
endmodule : tb_top
